// ==== core/adcsel_top.sv ====
/*
 * Input select and interrupt status block of the converter front end.
 * Holds the channel select register and decodes it to positive and negative
 * mux routes, keeps the sticky completion flags, and serves all over APB.
 * Assumes done and clear events are one-cycle pulses synchronous to pclk.
 */
//
// Summary of operation
// (R1) Positive codes: analog inputs, then amplifier outputs
// (R2) Upper positive codes: monitors, then ground/half-DVDD
// (R3) Negative field readable, writable, resets to zero
// (R4) Normal mode: negative field steers negative mux for analog input and amplifier codes
// (R5) Status bit one flags sequence completion
// (R6) Status bit zero flags single conversion completion
// (R7) Sequencer flag only set when enabled
// (R8) Negative codes: references, then odd inputs
`timescale 1ns/1ps

module adcsel_top
	import adcsel_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic normal_mode,
	input wire logic single_conversion_done,
	input wire logic sequence_done,
	input wire logic single_conversion_clear,
	input wire logic sequence_clear,
	output logic [4:0] positive_input_select,
	output logic [3:0] negative_input_select,
	output adcsel_route_t positive_route,
	output adcsel_route_t negative_route,
	output logic single_conversion_done_flag,
	output logic sequence_done_flag,
	output logic sequencer_irq_enable,
	output logic half_dvdd_select
);

	// Address decode, used by both the read path and the write path
	function automatic adcsel_reg_t decode_addr(input logic [31:0] addr);
		case (addr)
			ADCSEL_CHANNEL_SELECT_ADDR: decode_addr = ADCSEL_REG_CHANNEL_SELECT;
			ADCSEL_INTERRUPT_STATUS_ADDR: decode_addr = ADCSEL_REG_INTERRUPT_STATUS;
			ADCSEL_SEQ_CONTROL_ADDR: decode_addr = ADCSEL_REG_SEQ_CONTROL;
			ADCSEL_ADC_CONTROL_ADDR: decode_addr = ADCSEL_REG_ADC_CONTROL;
			default: decode_addr = ADCSEL_REG_NONE;
		endcase
	endfunction

	// Positive code to source route
	function automatic adcsel_route_t decode_positive(input logic [4:0] code,
		input logic half_dvdd);
		adcsel_route_t r;
		r.index = code[3:0];
		if (code < ADCSEL_POS_AMP_FIRST) begin
			r.kind = ADCSEL_SRC_ANALOG_INPUT; // R1
		end else if (code < ADCSEL_POS_TEMP) begin
			r.kind = ADCSEL_SRC_AMPLIFIER_OUTPUT; // R1
			r.index = {2'b00, code[1:0]};
		end else if (code == ADCSEL_POS_TEMP) begin
			r.kind = ADCSEL_SRC_TEMPERATURE; // R2
		end else if (code == ADCSEL_POS_AVDD_HALF) begin
			r.kind = ADCSEL_SRC_AVDD_HALF; // R2
		end else if (code == ADCSEL_POS_IO0_HALF) begin
			r.kind = ADCSEL_SRC_FIRST_IO_SUPPLY_HALF; // R2
		end else if (code == ADCSEL_POS_IO1) begin
			r.kind = ADCSEL_SRC_SECOND_IO_SUPPLY; // R2
		end else if (code < ADCSEL_POS_RESERVED_FIRST) begin
			r.kind = half_dvdd ? ADCSEL_SRC_DVDD_HALF : ADCSEL_SRC_GROUND; // R2
		end else begin
			r.kind = ADCSEL_SRC_RESERVED; // R1
		end
		if (r.kind != ADCSEL_SRC_ANALOG_INPUT && r.kind != ADCSEL_SRC_AMPLIFIER_OUTPUT) begin
			r.index = 4'h0;
		end
		decode_positive = r;
	endfunction

	// Negative code to source route
	function automatic adcsel_route_t decode_negative(input logic [3:0] code);
		adcsel_route_t r;
		logic [3:0] offset;
		offset = code - ADCSEL_NEG_ODD_FIRST;
		r.index = 4'h0;
		if (code == ADCSEL_NEG_NEGREF || code >= ADCSEL_NEG_NEGREF_FIRST) begin
			r.kind = ADCSEL_SRC_NEGATIVE_REFERENCE; // R3 R8
		end else if (code == ADCSEL_NEG_POSREF) begin
			r.kind = ADCSEL_SRC_POSITIVE_REFERENCE; // R8
		end else begin
			// Odd inputs 1..15: index = 2*(code-2)+1; the offset is taken on the
			// full code so codes 8 and 9 do not wrap back onto low inputs
			r.kind = ADCSEL_SRC_ANALOG_INPUT; // R8
			r.index = {offset[2:0], 1'b1};
		end
		decode_negative = r;
	endfunction

	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [4:0] next_positive_input_select;
	logic [3:0] next_negative_input_select;
	adcsel_route_t next_positive_route;
	adcsel_route_t next_negative_route;
	logic next_single_conversion_done_flag;
	logic next_sequence_done_flag;
	logic next_sequencer_irq_enable;
	logic next_half_dvdd_select;
	adcsel_reg_t sel_reg;
	logic write_now;

	assign sel_reg = decode_addr(paddr);
	// A write lands only at the completing edge of the access phase
	assign write_now = psel & penable & pready & pwrite;

	// Bus answer: one wait-free access, read data and error set up in the
	// setup cycle so every bus output comes from a flip-flop
	always_comb begin
		next_pready = psel & ~penable & ~pready;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		if (psel & ~penable) begin
			next_pslverr = (sel_reg == ADCSEL_REG_NONE);
			if (!pwrite) begin
				case (sel_reg)
					ADCSEL_REG_CHANNEL_SELECT: begin
						next_prdata[ADCSEL_POS_MSB:ADCSEL_POS_LSB] = positive_input_select;
						next_prdata[ADCSEL_NEG_MSB:ADCSEL_NEG_LSB] = negative_input_select; // R3
					end
					ADCSEL_REG_INTERRUPT_STATUS: begin
						next_prdata[ADCSEL_CONV_FLAG_BIT] = single_conversion_done_flag; // R6
						next_prdata[ADCSEL_SEQ_FLAG_BIT] = sequence_done_flag; // R5
					end
					ADCSEL_REG_SEQ_CONTROL: begin
						next_prdata[ADCSEL_SEQ_IRQ_EN_BIT] = sequencer_irq_enable;
					end
					ADCSEL_REG_ADC_CONTROL: begin
						next_prdata[ADCSEL_HALF_DVDD_BIT] = half_dvdd_select;
					end
					default: begin
						next_prdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// Register writes; status is read-only so bus writes to it are dropped
	always_comb begin
		next_positive_input_select = positive_input_select;
		next_negative_input_select = negative_input_select;
		next_sequencer_irq_enable = sequencer_irq_enable;
		next_half_dvdd_select = half_dvdd_select;
		if (write_now) begin
			case (sel_reg)
				ADCSEL_REG_CHANNEL_SELECT: begin
					next_positive_input_select = pwdata[ADCSEL_POS_MSB:ADCSEL_POS_LSB]; // R1
					next_negative_input_select = pwdata[ADCSEL_NEG_MSB:ADCSEL_NEG_LSB]; // R3
				end
				ADCSEL_REG_SEQ_CONTROL: begin
					next_sequencer_irq_enable = pwdata[ADCSEL_SEQ_IRQ_EN_BIT];
				end
				ADCSEL_REG_ADC_CONTROL: begin
					next_half_dvdd_select = pwdata[ADCSEL_HALF_DVDD_BIT];
				end
				default: begin
					next_half_dvdd_select = half_dvdd_select;
				end
			endcase
		end
	end

	// Routes follow the registered codes one cycle later; the negative
	// mux stage is only steered by the field in normal mode for inputs
	// that are measured differentially, else it parks on the reference
	always_comb begin
		next_positive_route = decode_positive(positive_input_select, half_dvdd_select); // R1 R2
		if (normal_mode && (next_positive_route.kind == ADCSEL_SRC_ANALOG_INPUT ||
			next_positive_route.kind == ADCSEL_SRC_AMPLIFIER_OUTPUT)) begin
			next_negative_route = decode_negative(negative_input_select); // R4
		end else begin
			next_negative_route.kind = ADCSEL_SRC_NEGATIVE_REFERENCE;
			next_negative_route.index = 4'h0;
		end
	end

	// Sticky flags: a done event in the clearing cycle wins over the clear
	always_comb begin
		next_single_conversion_done_flag = single_conversion_done_flag;
		next_sequence_done_flag = sequence_done_flag;
		if (single_conversion_clear) begin
			next_single_conversion_done_flag = 1'b0;
		end
		if (sequence_clear) begin
			next_sequence_done_flag = 1'b0;
		end
		if (single_conversion_done) begin
			next_single_conversion_done_flag = 1'b1; // R6
		end
		if (sequence_done && sequencer_irq_enable) begin
			next_sequence_done_flag = 1'b1; // R5 R7
		end
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			positive_input_select <= ADCSEL_CHANNEL_SELECT_RESET[ADCSEL_POS_MSB:ADCSEL_POS_LSB];
			negative_input_select <= ADCSEL_CHANNEL_SELECT_RESET[ADCSEL_NEG_MSB:ADCSEL_NEG_LSB];
			positive_route <= '{kind: ADCSEL_SRC_ANALOG_INPUT, index: 4'h0};
			negative_route <= '{kind: ADCSEL_SRC_NEGATIVE_REFERENCE, index: 4'h0};
			single_conversion_done_flag <= ADCSEL_INTERRUPT_STATUS_RESET[ADCSEL_CONV_FLAG_BIT];
			sequence_done_flag <= ADCSEL_INTERRUPT_STATUS_RESET[ADCSEL_SEQ_FLAG_BIT];
			sequencer_irq_enable <= ADCSEL_SEQ_CONTROL_RESET[ADCSEL_SEQ_IRQ_EN_BIT];
			half_dvdd_select <= ADCSEL_ADC_CONTROL_RESET[ADCSEL_HALF_DVDD_BIT];
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			positive_input_select <= next_positive_input_select;
			negative_input_select <= next_negative_input_select;
			positive_route <= next_positive_route;
			negative_route <= next_negative_route;
			single_conversion_done_flag <= next_single_conversion_done_flag;
			sequence_done_flag <= next_sequence_done_flag;
			sequencer_irq_enable <= next_sequencer_irq_enable;
			half_dvdd_select <= next_half_dvdd_select;
		end
	end

endmodule

// ==== core/adcsel_pkg.sv ====
/*
 * Package for the input select and interrupt status block: register map,
 * field layouts, reset values and the route types driven to the mux.
 * Assumes a 32-bit APB bus with byte addresses and word-aligned registers.
 */
package adcsel_pkg;

	// Register byte addresses
	localparam logic [31:0] ADCSEL_CHANNEL_SELECT_ADDR = 32'h4006_8088;
	localparam logic [31:0] ADCSEL_INTERRUPT_STATUS_ADDR = 32'h4006_808c;
	localparam logic [31:0] ADCSEL_SEQ_CONTROL_ADDR = 32'h4006_8090;
	localparam logic [31:0] ADCSEL_ADC_CONTROL_ADDR = 32'h4006_8200;

	// Reset values
	localparam logic [31:0] ADCSEL_CHANNEL_SELECT_RESET = 32'h0000_0000;
	localparam logic [31:0] ADCSEL_INTERRUPT_STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] ADCSEL_SEQ_CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] ADCSEL_ADC_CONTROL_RESET = 32'h0000_0000;

	// Field positions
	localparam int ADCSEL_POS_LSB = 0;
	localparam int ADCSEL_POS_MSB = 4;
	localparam int ADCSEL_NEG_LSB = 5;
	localparam int ADCSEL_NEG_MSB = 8;
	localparam int ADCSEL_CONV_FLAG_BIT = 0;
	localparam int ADCSEL_SEQ_FLAG_BIT = 1;
	localparam int ADCSEL_SEQ_IRQ_EN_BIT = 3;
	localparam int ADCSEL_HALF_DVDD_BIT = 8;

	// Positive select code boundaries
	localparam logic [4:0] ADCSEL_POS_AMP_FIRST = 5'h10;
	localparam logic [4:0] ADCSEL_POS_TEMP = 5'h14;
	localparam logic [4:0] ADCSEL_POS_AVDD_HALF = 5'h15;
	localparam logic [4:0] ADCSEL_POS_IO0_HALF = 5'h16;
	localparam logic [4:0] ADCSEL_POS_IO1 = 5'h17;
	localparam logic [4:0] ADCSEL_POS_GROUND_FIRST = 5'h18;
	localparam logic [4:0] ADCSEL_POS_RESERVED_FIRST = 5'h1e;

	// Negative select code boundaries
	localparam logic [3:0] ADCSEL_NEG_NEGREF = 4'h0;
	localparam logic [3:0] ADCSEL_NEG_POSREF = 4'h1;
	localparam logic [3:0] ADCSEL_NEG_ODD_FIRST = 4'h2;
	localparam logic [3:0] ADCSEL_NEG_NEGREF_FIRST = 4'ha;

	// Source kinds routed onto the converter inputs
	typedef enum logic [3:0] {
		ADCSEL_SRC_ANALOG_INPUT,
		ADCSEL_SRC_AMPLIFIER_OUTPUT,
		ADCSEL_SRC_TEMPERATURE,
		ADCSEL_SRC_AVDD_HALF,
		ADCSEL_SRC_FIRST_IO_SUPPLY_HALF,
		ADCSEL_SRC_SECOND_IO_SUPPLY,
		ADCSEL_SRC_GROUND,
		ADCSEL_SRC_DVDD_HALF,
		ADCSEL_SRC_NEGATIVE_REFERENCE,
		ADCSEL_SRC_POSITIVE_REFERENCE,
		ADCSEL_SRC_RESERVED
	} adcsel_src_t;

	// One mux route: what kind of source and which index within it
	typedef struct packed {
		adcsel_src_t kind;
		logic [3:0] index;
	} adcsel_route_t;

	// Register index seen by the bus decoder
	typedef enum logic [2:0] {
		ADCSEL_REG_CHANNEL_SELECT,
		ADCSEL_REG_INTERRUPT_STATUS,
		ADCSEL_REG_SEQ_CONTROL,
		ADCSEL_REG_ADC_CONTROL,
		ADCSEL_REG_NONE
	} adcsel_reg_t;

endpackage

// ==== dv/adcsel_sva.sv ====
/*
 * Checker for the input select and status block, bound to adcsel_top.
 * Sees only the top ports; assumes one pclk domain and async presetn.
 */
`timescale 1ns/1ps

module adcsel_sva
	import adcsel_pkg::*;
(
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	input logic normal_mode,
	input logic single_conversion_done,
	input logic sequence_done,
	input logic single_conversion_clear,
	input logic sequence_clear,
	input logic [4:0] positive_input_select,
	input logic [3:0] negative_input_select,
	input adcsel_route_t positive_route,
	input adcsel_route_t negative_route,
	input logic single_conversion_done_flag,
	input logic sequence_done_flag,
	input logic sequencer_irq_enable,
	input logic half_dvdd_select
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Completed write to the channel select register
	sequence cs_write;
		psel && penable && pready && pwrite && paddr == ADCSEL_CHANNEL_SELECT_ADDR;
	endsequence

	chk_select_write: assert property (cs_write |=> negative_input_select == $past(pwdata[8:5])
		&& positive_input_select == $past(pwdata[4:0])) else $error("select write lost");
	chk_pos_input: assert property (!positive_input_select[4] |=> positive_route.index
		== $past(positive_input_select[3:0]) && positive_route.kind == ADCSEL_SRC_ANALOG_INPUT)
		else $error("positive input route wrong");
	chk_pos_ground: assert property (positive_input_select[4:3] == 2'b11 && positive_input_select
		< 5'h1e |=> positive_route.kind == ($past(half_dvdd_select) ? ADCSEL_SRC_DVDD_HALF
		: ADCSEL_SRC_GROUND)) else $error("ground route wrong");
	chk_neg_idle: assert property (!normal_mode |=> negative_route.kind ==
		ADCSEL_SRC_NEGATIVE_REFERENCE) else $error("negative route not idle");
	chk_conv_set: assert property (single_conversion_done |=> single_conversion_done_flag)
		else $error("conversion flag not set");
	chk_conv_clear: assert property (single_conversion_clear && !single_conversion_done |=>
		!single_conversion_done_flag) else $error("conversion flag not cleared");
	chk_seq_set: assert property (sequence_done && sequencer_irq_enable |=> sequence_done_flag)
		else $error("sequence flag not set");
	chk_seq_gate: assert property (sequence_done && !sequencer_irq_enable && !sequence_done_flag
		|=> !sequence_done_flag) else $error("gated sequence flag set");
	chk_status_read: assert property (pready && !pwrite && paddr == ADCSEL_INTERRUPT_STATUS_ADDR
		|-> prdata == {30'h0, $past(sequence_done_flag), $past(single_conversion_done_flag)})
		else $error("status read wrong");
endmodule

bind adcsel_top adcsel_sva u_sva (.*);

// ==== dv/test_adcsel_top.sv ====
/*
 * Testbench for adcsel_top: APB tasks, route tables and flag events.
 * Assumes the pready latency of one access cycle and one-cycle route lag.
 */
`timescale 1ns/1ps

module test_adcsel_top;
	import adcsel_pkg::*;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, normal_mode, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0] ev;
	adcsel_route_t pos_rt, neg_rt;
	int errors = 0;
	int checked = 0;

	// Free-running 100 MHz clock
	always #5 pclk = ~pclk;

	adcsel_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .normal_mode(normal_mode), .single_conversion_done(ev[0]),
		.sequence_done(ev[1]), .single_conversion_clear(ev[2]), .sequence_clear(ev[3]),
		.positive_input_select(), .negative_input_select(), .positive_route(pos_rt),
		.negative_route(neg_rt), .single_conversion_done_flag(), .sequence_done_flag(),
		.sequencer_irq_enable(), .half_dvdd_select());

	task automatic stop_test();
		if (errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask

	// One APB transfer; an idle cycle after it keeps psel from toggling twice
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			$display("MISMATCH pready expected 1 seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic pulse(input logic [3:0] v);
		ev <= v;
		@(posedge pclk);
		ev <= 4'h0;
		@(posedge pclk);
	endtask

	// Monitor kinds 20..23 follow the enum order, so kind = code - 18
	function automatic logic [31:0] exp_pos(input int c, input logic hd);
		if (c < 16) return {24'h0, ADCSEL_SRC_ANALOG_INPUT, 4'(c)};
		if (c < 20) return {24'h0, ADCSEL_SRC_AMPLIFIER_OUTPUT, 4'(c - 16)};
		if (c < 24) return {24'h0, 4'(c - 18), 4'h0};
		if (c < 30) return {24'h0, hd ? ADCSEL_SRC_DVDD_HALF : ADCSEL_SRC_GROUND, 4'h0};
		return {24'h0, ADCSEL_SRC_RESERVED, 4'h0};
	endfunction

	function automatic logic [31:0] exp_neg(input int n);
		if (n == 1) return {24'h0, ADCSEL_SRC_POSITIVE_REFERENCE, 4'h0};
		if (n >= 2 && n <= 9) return {24'h0, ADCSEL_SRC_ANALOG_INPUT, 4'(2 * n - 3)};
		return {24'h0, ADCSEL_SRC_NEGATIVE_REFERENCE, 4'h0};
	endfunction

	// Watchdog: the whole run needs about 500 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		stop_test();
	end

	initial begin
		{presetn, psel, penable, pwrite, normal_mode, ev, paddr, pwdata} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("neg_route", exp_neg(0), {24'h0, neg_rt});
		apb(1'b0, ADCSEL_CHANNEL_SELECT_ADDR, 32'h0);
		check("select_reset", 32'h0, rd);
		apb(1'b0, 32'h4006_8100, 32'h0);
		check("unmapped_err", 32'h1, {31'h0, err});
		// Every positive code, both ground settings; negative field on odd input 11
		normal_mode <= 1'b1;
		for (int h = 0; h < 2; h++) begin
			apb(1'b1, ADCSEL_ADC_CONTROL_ADDR, 32'(h) << 8);
			for (int c = 0; c < 32; c++) begin
				apb(1'b1, ADCSEL_CHANNEL_SELECT_ADDR, 32'hffff_fee0 | 32'(c));
				apb(1'b0, ADCSEL_CHANNEL_SELECT_ADDR, 32'h0);
				check("select_read", 32'h0000_00e0 | 32'(c), rd);
				check("pos_route", exp_pos(c, h[0]), {24'h0, pos_rt});
				check("neg_route", c < 20 ? exp_neg(7) : exp_neg(0), {24'h0, neg_rt});
			end
		end
		// Every negative code behind an amplifier output, then outside normal mode
		for (int n = 0; n < 16; n++) begin
			apb(1'b1, ADCSEL_CHANNEL_SELECT_ADDR, (32'(n) << 5) | 32'h0000_0013);
			@(posedge pclk);
			check("neg_route", exp_neg(n), {24'h0, neg_rt});
		end
		normal_mode <= 1'b0;
		repeat (2) @(posedge pclk);
		check("neg_idle", exp_neg(0), {24'h0, neg_rt});
		// Status flags: write ignored, set, gate, set-over-clear, clear
		apb(1'b1, ADCSEL_INTERRUPT_STATUS_ADDR, 32'hffff_ffff);
		apb(1'b0, ADCSEL_INTERRUPT_STATUS_ADDR, 32'h0);
		check("status_ro", 32'h0, rd);
		pulse(4'b0011);
		apb(1'b0, ADCSEL_INTERRUPT_STATUS_ADDR, 32'h0);
		check("status_gated", 32'h1, rd);
		apb(1'b1, ADCSEL_SEQ_CONTROL_ADDR, 32'h0000_0008);
		apb(1'b0, ADCSEL_SEQ_CONTROL_ADDR, 32'h0);
		check("seq_enable", 32'h0000_0008, rd);
		apb(1'b0, ADCSEL_ADC_CONTROL_ADDR, 32'h0);
		check("half_dvdd", 32'h0000_0100, rd);
		pulse(4'b0110);
		apb(1'b0, ADCSEL_INTERRUPT_STATUS_ADDR, 32'h0);
		check("status_seq", 32'h2, rd);
		pulse(4'b1010);
		apb(1'b0, ADCSEL_INTERRUPT_STATUS_ADDR, 32'h0);
		check("seq_set_wins", 32'h2, rd);
		pulse(4'b0101);
		apb(1'b0, ADCSEL_INTERRUPT_STATUS_ADDR, 32'h0);
		check("conv_set_wins", 32'h3, rd);
		pulse(4'b1100);
		apb(1'b0, ADCSEL_INTERRUPT_STATUS_ADDR, 32'h0);
		check("status_clear", 32'h0, rd);
		stop_test();
	end
endmodule
